// file: trf_pkg.sv
package trf_pkg;
    // tape record geometry
    localparam int unsigned REC_BYTES = 8192;
    localparam int unsigned REC_WORDS = REC_BYTES / 2;
    localparam logic [11:0] LAST_WORD = 12'(REC_WORDS - 1);
    localparam logic [12:0] REC_WORDS_W = 13'(REC_WORDS);
    // data record layout
    localparam logic [10:0] HDR_WORDS = 11'h005;
    localparam logic [10:0] MAX_DREC_WORDS = 11'h400;
    localparam logic [10:0] MAX_DATA_WORDS = 11'(MAX_DREC_WORDS - HDR_WORDS);
    localparam logic [2:0] HDR_LAST = 3'h4;
    // type codes
    localparam logic [2:0] TYPE_MIN = 3'h1;
    localparam logic [2:0] TYPE_MAX = 3'h6;
    // time limits
    localparam logic [31:0] MS_DAY_MAX = 32'h0526_5bff;
    localparam logic [15:0] DAY_MIN = 16'h0001;
    // chart relay closure lengths in seconds
    localparam logic [5:0] MIN_CLOSE_S = 6'h01;
    localparam logic [5:0] HOUR_CLOSE_S = 6'h03;
    localparam logic [5:0] DAY_CLOSE_S = 6'h1e;
    // end-of-file mark counts
    localparam logic [1:0] EOT_MARKS = 2'h2;
    localparam logic [1:0] ONE_MARK = 2'h1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HDR = 3'b001,
        ST_DATA = 3'b010,
        ST_PAD = 3'b011,
        ST_MARK = 3'b100,
        ST_DONE = 3'b101
    } trf_state_e;
endpackage

// file: trf_framer.sv
// Functional notes
// - every tape record is exactly 8192 bytes
// - words go out high byte then low
// - ninth track is odd parity; end-of-file mark frames go out as byte zero with parity zero
// - density selectable, phase-encoded by default
// - data record is five-word header plus data
// - header order: type, count, three time words
// - data record never longer than 1024 words
// - unused record words are written as zero
// - type code must be one to six
// - block count equals words including header
// - end-of-file mark at each hour start
// - two end-of-file marks make logical end; an end-of-tape request during a lone hourly mark ends after that one mark
// - day word is 16-bit count from one
// - millisecond of day, high word first, bounded
// - records of one type in time order
// - chart relay closes one second each minute
// - relay open on minutes ending nine; longer marks
module trf_framer
    import trf_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic srst_in,
    // data record request: header fields and data length
    input wire logic rec_valid_in,
    output logic rec_ready_out,
    output logic rec_reject_out,
    input wire logic [2:0] rec_type_in,
    input wire logic [10:0] rec_len_in,
    input wire logic [15:0] rec_day_in,
    input wire logic [31:0] rec_ms_in,
    // data words of the accepted record
    input wire logic dat_valid_in,
    output logic dat_ready_out,
    input wire logic [15:0] dat_word_in,
    // time of day from the local timebase
    input wire logic [4:0] hour_in,
    input wire logic [5:0] min_in,
    input wire logic [5:0] sec_in,
    // mode and end-of-tape request
    input wire logic dens_low_in,
    input wire logic eot_req_in,
    output logic eot_done_out,
    // byte stream to the tape drive
    output logic tape_valid_out,
    input wire logic tape_ready_in,
    output logic [7:0] tape_byte_out,
    output logic tape_parity_out,
    output logic tape_rec_end_out,
    output logic tape_mark_out,
    output logic tape_dens_low_out,
    // chart pen relay, high = contact closed
    output logic chart_relay_out
);
    trf_state_e state_q, state_d;
    logic [11:0] wcnt_q, wcnt_d;
    logic lo_q, lo_d;
    logic [2:0] hidx_q, hidx_d;
    logic [10:0] left_q, left_d;
    logic [2:0] type_q, type_d;
    logic [10:0] cnt_q, cnt_d;
    logic [15:0] day_q, day_d;
    logic [31:0] ms_q, ms_d;
    logic [1:0] marks_q, marks_d;
    logic eof_pend_q, eof_pend_d;
    logic eot_pend_q, eot_pend_d;
    logic dens_q, dens_d;
    logic [47:0] last_q [1:6];
    logic [47:0] last_d [1:6];
    logic ov_q, ov_d;
    logic [7:0] byte_q, byte_d;
    logic par_q, par_d;
    logic end_q, end_d;
    logic mark_q, mark_d;
    logic rej_q, rej_d;
    logic [4:0] hr_prev_q, hr_prev_d;
    logic hr_seen_q, hr_seen_d;
    logic relay_q, relay_d;

    logic fire;
    logic [10:0] need;
    logic [12:0] room;
    logic type_ok;
    logic rec_ok;
    logic [15:0] hword;
    logic [15:0] cur_word;
    logic [7:0] cur_byte;
    logic hour_tick;
    logic min_nine;

    // output slot is free when empty or the drive takes the byte now
    assign fire = !ov_q || tape_ready_in;
    assign need = HDR_WORDS + rec_len_in;
    assign room = REC_WORDS_W - {1'b0, wcnt_q};
    assign type_ok = (rec_type_in >= TYPE_MIN) && (rec_type_in <= TYPE_MAX);
    assign hour_tick = hr_seen_q && (hour_in != hr_prev_q);
    assign min_nine = (min_in == 6'h09) || (min_in == 6'h13) || (min_in == 6'h1d) ||
                      (min_in == 6'h27) || (min_in == 6'h31) || (min_in == 6'h3b);

    // request checks; the time order compare needs the request's type in range
    always_comb begin
        rec_ok = type_ok && (rec_len_in <= MAX_DATA_WORDS);
        rec_ok = rec_ok && (rec_day_in >= DAY_MIN);
        rec_ok = rec_ok && (rec_ms_in <= MS_DAY_MAX);
        if (type_ok) begin
            rec_ok = rec_ok && ({rec_day_in, rec_ms_in} >= last_q[rec_type_in]);
        end
    end

    // header word selected by index, in the fixed header order
    always_comb begin
        unique case (hidx_q)
            3'h0: hword = {13'h0000, type_q};
            3'h1: hword = {5'h00, cnt_q};
            3'h2: hword = day_q;
            3'h3: hword = ms_q[31:16];
            default: hword = ms_q[15:0];
        endcase
    end

    // word now being sent; padding is zero
    always_comb begin
        unique case (state_q)
            ST_HDR: cur_word = hword;
            ST_DATA: cur_word = dat_word_in;
            default: cur_word = 16'h0000;
        endcase
        cur_byte = lo_q ? cur_word[7:0] : cur_word[15:8];
    end

    // framer: the byte slot, word counting and record sequencing
    always_comb begin
        state_d = state_q;
        wcnt_d = wcnt_q;
        lo_d = lo_q;
        hidx_d = hidx_q;
        left_d = left_q;
        type_d = type_q;
        cnt_d = cnt_q;
        day_d = day_q;
        ms_d = ms_q;
        marks_d = marks_q;
        eof_pend_d = eof_pend_q || hour_tick;
        eot_pend_d = eot_pend_q || eot_req_in;
        dens_d = dens_q;
        last_d = last_q;
        ov_d = ov_q && !tape_ready_in;
        byte_d = byte_q;
        par_d = par_q;
        end_d = end_q;
        mark_d = mark_q;
        rej_d = 1'b0;
        rec_ready_out = 1'b0;
        dat_ready_out = 1'b0;
        if (fire) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (eof_pend_q || eot_pend_q) begin
                        // close the open record first so the mark lands on a boundary
                        if (wcnt_q != 12'h000) begin
                            state_d = ST_PAD;
                        end else begin
                            state_d = ST_MARK;
                            marks_d = eot_pend_q ? EOT_MARKS : ONE_MARK;
                        end
                    end else if (rec_valid_in) begin
                        if (!rec_ok) begin
                            rec_ready_out = 1'b1;
                            rej_d = 1'b1;
                        end else if ({2'b00, need} > room) begin
                            state_d = ST_PAD;
                        end else begin
                            rec_ready_out = 1'b1;
                            type_d = rec_type_in;
                            cnt_d = need;
                            day_d = rec_day_in;
                            ms_d = rec_ms_in;
                            left_d = rec_len_in;
                            hidx_d = 3'h0;
                            last_d[rec_type_in] = {rec_day_in, rec_ms_in};
                            if (wcnt_q == 12'h000) begin
                                dens_d = dens_low_in;  // density only changes between records
                            end
                            state_d = ST_HDR;
                        end
                    end
                end
                ST_HDR, ST_DATA, ST_PAD: begin
                    if (state_q != ST_DATA || dat_valid_in) begin
                        ov_d = 1'b1;
                        byte_d = cur_byte;
                        par_d = ~^cur_byte;
                        mark_d = 1'b0;
                        end_d = lo_q && (wcnt_q == LAST_WORD);
                        lo_d = !lo_q;
                        if (lo_q) begin
                            wcnt_d = wcnt_q + 12'h001;  // wraps to zero at record end
                            if (state_q == ST_DATA) begin
                                dat_ready_out = 1'b1;
                                left_d = left_q - 11'h001;
                                if (left_q == 11'h001) begin
                                    state_d = ST_IDLE;
                                end
                            end else if (state_q == ST_HDR) begin
                                hidx_d = hidx_q + 3'h1;
                                if (hidx_q == HDR_LAST) begin
                                    state_d = (left_q == 11'h000) ? ST_IDLE : ST_DATA;
                                end
                            end else if (wcnt_q == LAST_WORD) begin
                                state_d = ST_IDLE;
                            end
                        end
                    end
                end
                ST_MARK: begin
                    ov_d = 1'b1;
                    byte_d = 8'h00;
                    par_d = 1'b0;
                    end_d = 1'b0;
                    mark_d = 1'b1;
                    marks_d = marks_q - 2'h1;
                    if (marks_q == ONE_MARK) begin
                        if (eot_pend_q) begin
                            state_d = ST_DONE;
                        end else begin
                            state_d = ST_IDLE;
                            eof_pend_d = hour_tick;
                        end
                    end
                end
                ST_DONE: begin
                    // logical end of tape reached; nothing more is written
                    state_d = ST_DONE;
                end
                default: state_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            state_q <= ST_IDLE;
            wcnt_q <= 12'h000;
            lo_q <= 1'b0;
            hidx_q <= 3'h0;
            left_q <= 11'h000;
            type_q <= 3'h0;
            cnt_q <= 11'h000;
            day_q <= 16'h0000;
            ms_q <= 32'h0000_0000;
            marks_q <= 2'h0;
            eof_pend_q <= 1'b0;
            eot_pend_q <= 1'b0;
            dens_q <= 1'b0;
            for (int i = 1; i <= 6; i++) begin
                last_q[i] <= 48'h0000_0000_0000;
            end
            ov_q <= 1'b0;
            byte_q <= 8'h00;
            par_q <= 1'b0;
            end_q <= 1'b0;
            mark_q <= 1'b0;
            rej_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wcnt_q <= wcnt_d;
            lo_q <= lo_d;
            hidx_q <= hidx_d;
            left_q <= left_d;
            type_q <= type_d;
            cnt_q <= cnt_d;
            day_q <= day_d;
            ms_q <= ms_d;
            marks_q <= marks_d;
            eof_pend_q <= eof_pend_d;
            eot_pend_q <= eot_pend_d;
            dens_q <= dens_d;
            last_q <= last_d;
            ov_q <= ov_d;
            byte_q <= byte_d;
            par_q <= par_d;
            end_q <= end_d;
            mark_q <= mark_d;
            rej_q <= rej_d;
        end
    end

    // chart relay and hour change; minute 59 ends in nine so the hour mark stands alone
    always_comb begin
        hr_prev_d = hour_in;
        hr_seen_d = 1'b1;
        if ((hour_in == 5'h00) && (min_in == 6'h00)) begin
            relay_d = sec_in < DAY_CLOSE_S;
        end else if (min_in == 6'h00) begin
            relay_d = sec_in < HOUR_CLOSE_S;
        end else begin
            relay_d = !min_nine && (sec_in < MIN_CLOSE_S);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            hr_prev_q <= 5'h00;
            hr_seen_q <= 1'b0;
            relay_q <= 1'b0;
        end else begin
            hr_prev_q <= hr_prev_d;
            hr_seen_q <= hr_seen_d;
            relay_q <= relay_d;
        end
    end

    assign tape_valid_out = ov_q;
    assign tape_byte_out = byte_q;
    assign tape_parity_out = par_q;
    assign tape_rec_end_out = end_q;
    assign tape_mark_out = mark_q;
    assign tape_dens_low_out = dens_q;
    assign rec_reject_out = rej_q;
    assign eot_done_out = (state_q == ST_DONE) && !ov_q;
    assign chart_relay_out = relay_q;
endmodule // trf_framer

// file: trf_framer_props.sv
module trf_framer_props
    import trf_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic rec_valid_in,
    input wire logic rec_ready_out,
    input wire logic rec_reject_out,
    input wire logic [2:0] rec_type_in,
    input wire logic [10:0] rec_len_in,
    input wire logic [15:0] rec_day_in,
    input wire logic [31:0] rec_ms_in,
    input wire logic [5:0] min_in,
    input wire logic [5:0] sec_in,
    input wire logic eot_done_out,
    input wire logic tape_valid_out,
    input wire logic tape_ready_in,
    input wire logic [7:0] tape_byte_out,
    input wire logic tape_parity_out,
    input wire logic tape_rec_end_out,
    input wire logic tape_mark_out,
    input wire logic chart_relay_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    logic take;
    logic [12:0] cnt_q;
    logic [12:0] cnt_d;
    assign take = rec_valid_in && rec_ready_out;
    // data byte position in the open tape record; marks do not count
    always_comb begin
        cnt_d = cnt_q;
        if (tape_valid_out && tape_ready_in && !tape_mark_out) begin
            cnt_d = tape_rec_end_out ? 13'h0000 : cnt_q + 13'h0001;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        cnt_q <= srst_in ? 13'h0000 : cnt_d;
    end
    property p_rec_len; tape_valid_out && !tape_mark_out |-> tape_rec_end_out == (cnt_q == 13'h1fff); endproperty
    a_rec_len: assert property (p_rec_len) else $error("record end not at byte 8192");
    property p_parity; tape_valid_out && !tape_mark_out |-> tape_parity_out == ~^tape_byte_out; endproperty
    a_parity: assert property (p_parity) else $error("parity not odd");
    property p_hold; tape_valid_out && !tape_ready_in |=> tape_valid_out && $stable(tape_byte_out); endproperty
    a_hold: assert property (p_hold) else $error("tape byte dropped before taken");
    property p_type; take && (rec_type_in < TYPE_MIN || rec_type_in > TYPE_MAX) |=> rec_reject_out; endproperty
    a_type: assert property (p_type) else $error("bad type accepted");
    property p_len; take && rec_len_in > MAX_DATA_WORDS |=> rec_reject_out; endproperty
    a_len: assert property (p_len) else $error("overlong record accepted");
    property p_day; take && rec_day_in == 16'h0000 |=> rec_reject_out; endproperty
    a_day: assert property (p_day) else $error("day zero accepted");
    property p_ms; take && rec_ms_in > MS_DAY_MAX |=> rec_reject_out; endproperty
    a_ms: assert property (p_ms) else $error("time of day out of range accepted");
    property p_min; sec_in == 6'h00 && min_in % 6'h0a != 6'h09 |=> chart_relay_out; endproperty
    a_min: assert property (p_min) else $error("relay open on the minute");
    property p_nine; sec_in == 6'h00 && min_in % 6'h0a == 6'h09 |=> !chart_relay_out; endproperty
    a_nine: assert property (p_nine) else $error("relay closed on a minute ending nine");
    property p_done; eot_done_out |=> eot_done_out; endproperty
    a_done: assert property (p_done) else $error("end of tape flag dropped");
endmodule // trf_framer_props

// file: trf_tape_model.sv
module trf_tape_model (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic slow_in,
    input wire logic valid_in,
    output logic ready_out,
    input wire logic [7:0] byte_in,
    input wire logic end_in,
    input wire logic mark_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [0:4095];
    logic [12:0] pos;
    logic [7:0] hi;
    logic [1:0] ph;
    int rec_n;
    int marks;
    int err;
    int run;
    // drive side: stalls one cycle in four when slow, keeps the first record as words
    // run counts file marks in a row, so data past the logical end is caught
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            ph <= 2'h0;
            ready_out <= 1'b0;
            pos <= 13'h0000;
            rec_n <= 0;
            marks <= 0;
            run <= 0;
            err <= 0;
        end else begin
            ph <= ph + 2'h1;
            ready_out <= !(slow_in && ph == 2'h2);
            if (valid_in && ready_out) begin
                if (mark_in) begin
                    if (pos != 13'h0000) err <= err + 1;
                    marks <= marks + 1;
                    run <= run + 1;
                end else begin
                    if (run >= 2) err <= err + 1; // nothing is valid past the logical end
                    run <= 0;
                    if (!pos[0]) hi <= byte_in;
                    else if (rec_n == 0) mem[pos[12:1]] <= {hi, byte_in}; // high byte first
                    pos <= end_in ? 13'h0000 : pos + 13'h0001;
                    if (end_in) rec_n <= rec_n + 1;
                end
            end
        end
    end
endmodule // trf_tape_model

// file: tape_record_framer_tb.sv
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tape_record_framer_tb
    import trf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [2:0] t; logic [10:0] l; logic [15:0] d; logic [31:0] ms; logic rj;} trf_row_s;
    trf_row_s rows [13] = '{'{1, 2, 1, 1000, 0}, '{0, 0, 1, 0, 1}, '{7, 0, 1, 0, 1}, '{2, 1020, 1, 0, 1},
        '{3, 0, 0, 0, 1}, '{4, 0, 1, 86400000, 1}, '{1, 0, 1, 999, 1}, '{2, 1019, 1, 0, 0}, '{3, 0, 1, 0, 0},
        '{4, 0, 1, 0, 0}, '{5, 0, 1, 86399999, 0}, '{6, 0, 65535, 0, 0}, '{1, 0, 1, 1000, 0}};
    logic sys_clk_in = 0, srst_in, rec_valid_in, rec_ready_out, rec_reject_out, dat_valid_in, dat_ready_out;
    logic [2:0] rec_type_in;
    logic [10:0] rec_len_in;
    logic [15:0] rec_day_in, dat_word_in;
    logic [31:0] rec_ms_in;
    logic [4:0] hour_in;
    logic [5:0] min_in, sec_in;
    logic dens_low_in, eot_req_in, eot_done_out, tape_valid_out, tape_ready_in, tape_parity_out;
    logic [7:0] tape_byte_out;
    logic tape_rec_end_out, tape_mark_out, tape_dens_low_out, chart_relay_out, slow;
    logic [15:0] exp_w [$];
    int n_mismatch = 0, n_checks = 0, n_dat = 0, k, goal;
    trf_framer i_trf_framer (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .rec_valid_in(rec_valid_in),
        .rec_ready_out(rec_ready_out), .rec_reject_out(rec_reject_out), .rec_type_in(rec_type_in),
        .rec_len_in(rec_len_in), .rec_day_in(rec_day_in), .rec_ms_in(rec_ms_in), .dat_valid_in(dat_valid_in),
        .dat_ready_out(dat_ready_out), .dat_word_in(dat_word_in), .hour_in(hour_in), .min_in(min_in),
        .sec_in(sec_in), .dens_low_in(dens_low_in), .eot_req_in(eot_req_in), .eot_done_out(eot_done_out),
        .tape_valid_out(tape_valid_out), .tape_ready_in(tape_ready_in), .tape_byte_out(tape_byte_out),
        .tape_parity_out(tape_parity_out), .tape_rec_end_out(tape_rec_end_out), .tape_mark_out(tape_mark_out),
        .tape_dens_low_out(tape_dens_low_out), .chart_relay_out(chart_relay_out));
    trf_tape_model i_trf_tape_model (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .slow_in(slow),
        .valid_in(tape_valid_out), .ready_out(tape_ready_in), .byte_in(tape_byte_out),
        .end_in(tape_rec_end_out), .mark_in(tape_mark_out));
    // 40 MHz clock
    always #12.5 sys_clk_in = ~sys_clk_in;
    // data source: next word once the current one is consumed
    always @(negedge sys_clk_in) begin
        if (dat_ready_out === 1'b1) begin
            @(posedge sys_clk_in);
            #1;
            dat_word_in = dat_word_in + 16'h0001;
            n_dat++;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic results();
        if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // a wait that runs out is a failure and ends the run
    task automatic bound(input int lim);
        if (k >= lim) begin
            n_mismatch++;
            results();
        end
    endtask
    // reset, request table, relay sweep, hourly mark, logical end of tape
    initial begin
        {srst_in, rec_valid_in, dat_valid_in, dens_low_in, eot_req_in, min_in, sec_in} = '1;
        {rec_valid_in, dat_valid_in, dens_low_in, eot_req_in, min_in, sec_in, rec_type_in, rec_len_in} = '0;
        {rec_day_in, rec_ms_in} = '0;
        dat_word_in = 16'h1230;
        hour_in = 5'h01;
        slow = 1'b1;
        tick(3);
        `CHK({tape_valid_out, rec_reject_out, eot_done_out, chart_relay_out}, 4'h0)
        srst_in = 1'b0;
        dat_valid_in = 1'b1;
        foreach (rows[i]) begin
            {rec_type_in, rec_len_in, rec_day_in, rec_ms_in} = {rows[i].t, rows[i].l, rows[i].d, rows[i].ms};
            rec_valid_in = 1'b1;
            goal = n_dat + (rows[i].rj ? 0 : int'(rows[i].l));
            if (!rows[i].rj) begin
                exp_w.push_back(16'(rows[i].t));
                exp_w.push_back(16'(rows[i].l) + 16'(HDR_WORDS));
                exp_w.push_back(rows[i].d);
                exp_w.push_back(rows[i].ms[31:16]);
                exp_w.push_back(rows[i].ms[15:0]);
                for (int j = 0; j < int'(rows[i].l); j++) exp_w.push_back(dat_word_in + 16'(j));
            end
            for (k = 0; k < 20000 && rec_ready_out !== 1'b1; k++) @(negedge sys_clk_in);
            bound(20000);
            tick(1);
            rec_valid_in = 1'b0;
            `CHK(rec_reject_out, rows[i].rj)
            for (k = 0; k < 20000 && n_dat < goal; k++) tick(1);
            bound(20000);
            tick(12);
        end
        for (int m = 0; m < 20; m++) begin
            min_in = 6'(m);
            sec_in = 6'h00;
            tick(2);
            `CHK(chart_relay_out, m % 10 != 9)
            sec_in = 6'h02;
            tick(1);
            `CHK(chart_relay_out, m == 0)
        end
        hour_in = 5'h02;
        for (k = 0; k < 40000 && i_trf_tape_model.marks != 1; k++) tick(1);
        bound(40000);
        `CHK(i_trf_tape_model.rec_n, 1)
        `CHK(tape_dens_low_out, 1'b0)
        `CHK(i_trf_tape_model.mem[0], 16'h0001)
        `CHK(i_trf_tape_model.mem[1], 16'h0007)
        for (int w = 0; w < 4096; w++) begin
            `CHK(i_trf_tape_model.mem[w], (w < exp_w.size()) ? exp_w[w] : 16'h0000)
        end
        // walk the kept record as a reader does, by block count, until a zero type code
        k = 0;
        for (int r = 0; r < 20 && i_trf_tape_model.mem[k] != 16'h0000; r++) begin
            k += int'(i_trf_tape_model.mem[k + 1]);
        end
        `CHK(k, exp_w.size())
        // one short low density record after the file mark, then the logical end
        dens_low_in = 1'b1;
        {rec_type_in, rec_len_in, rec_day_in, rec_ms_in} = {3'h5, 11'h001, 16'h0002, 32'h0000_0000};
        rec_valid_in = 1'b1;
        for (k = 0; k < 100 && rec_ready_out !== 1'b1; k++) tick(1);
        bound(100);
        tick(1);
        rec_valid_in = 1'b0;
        `CHK(tape_dens_low_out, 1'b1)
        eot_req_in = 1'b1;
        for (k = 0; k < 40000 && eot_done_out !== 1'b1; k++) tick(1);
        bound(40000);
        tick(20);
        `CHK(i_trf_tape_model.marks, 3)
        `CHK(i_trf_tape_model.err, 0)
        `CHK(i_trf_tape_model.rec_n, 2)
        results();
    end
endmodule // tape_record_framer_tb
bind trf_framer trf_framer_props i_trf_framer_props (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .rec_valid_in(rec_valid_in), .rec_ready_out(rec_ready_out), .rec_reject_out(rec_reject_out),
    .rec_type_in(rec_type_in), .rec_len_in(rec_len_in), .rec_day_in(rec_day_in), .rec_ms_in(rec_ms_in),
    .min_in(min_in), .sec_in(sec_in), .eot_done_out(eot_done_out), .tape_valid_out(tape_valid_out),
    .tape_ready_in(tape_ready_in), .tape_byte_out(tape_byte_out), .tape_parity_out(tape_parity_out),
    .tape_rec_end_out(tape_rec_end_out), .tape_mark_out(tape_mark_out), .chart_relay_out(chart_relay_out));
